// ===== umr_regmap.sv
// umr_regmap.sv: memory-space register window of a two-channel serial
// bridge, with receive and transmit queues behind the holding locations.
// assumes the host presents one-cycle requests on i_mclk and the receiver
// and serializer are logic on the same clock.
//
// Function
// - each channel owns a 512-byte window
// - channel base is memory base plus 0/200h
// - offset 00h: read receive, write transmit
// - offset 02h: read interrupt status, write control
// - divisor bytes write-only at 08h, 09h
// - receive holding read pops oldest entry
// - empty receive read gives undefined data
// - transmit holding write appends at tail
// - write to full transmit queue is dropped
// - line status shows queue full and empty
// - 100h-17Fh map queue data bytes
// - 180h-1FFh map per-entry status bytes
// - 15h: receive count or error count
// - 16h: sample clock or transmit count
`timescale 1ns/1ps
`include "umr_params.svh"

module umr_regmap (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [31:0] i_mem_base,
   input wire logic i_req,
   input wire umr_pkg::umr_req_t i_req_bus,
   output logic o_ack,
   output logic [7:0] o_rdata,
   input wire logic [1:0] i_rx_valid,
   input wire umr_pkg::umr_rx_t [1:0] i_rx,
   output logic [1:0] o_rx_ready,
   output logic [1:0] o_tx_valid,
   output logic [1:0][7:0] o_tx_data,
   input wire logic [1:0] i_tx_ready,
   output umr_pkg::umr_cfg_t [1:0] o_cfg
);

   umr_pkg::umr_state_t st_r;
   umr_pkg::umr_state_t st_nxt;

   // storage is not reset; pointers and counts define what is valid
   logic [7:0] rx_dmem [2][128];
   logic [7:0] rx_smem [2][128];
   logic [7:0] tx_mem [2][128];

   logic [31:0] off;
   logic [8:0] ofs;
   logic hit;
   logic [1:0] sel;
   logic [1:0] rd;
   logic [1:0] wr;
   logic [1:0] win_wr;
   umr_pkg::umr_area_t area;
   logic [1:0] rx_push;
   logic [1:0] rx_pop;
   logic [1:0] tx_push;
   logic [1:0] tx_pop;
   logic [1:0] buf_ready;
   logic [1:0] rx_dwe;
   logic [1:0] rx_swe;
   logic [1:0][`UMR_QAW-1:0] rx_wa;
   logic [1:0][7:0] rx_wd;
   logic [1:0][7:0] rx_ws;
   logic [1:0] tx_we;

   function automatic umr_pkg::umr_area_t umr_area(input logic [8:0] a);
      if (!a[8]) begin
         return umr_pkg::UMR_AREA_REG;
      end else if (!a[7]) begin
         return umr_pkg::UMR_AREA_DATA;
      end
      return umr_pkg::UMR_AREA_STAT;
   endfunction

   function automatic logic [7:0] umr_isr(input umr_pkg::umr_chan_t c);
      if (c.interrupt_enable[`UMR_IER_RXERR] && (c.err_cnt != 8'h00)) begin
         return `UMR_ISR_RXERR;
      end else if (c.interrupt_enable[`UMR_IER_RXAV] && (c.rx_cnt != 8'h00)) begin
         return `UMR_ISR_RXAV;
      end else if (c.interrupt_enable[`UMR_IER_TXE] && (c.tx_cnt == 8'h00)) begin
         return `UMR_ISR_TXE;
      end
      return `UMR_ISR_NONE;
   endfunction

   function automatic logic [7:0] umr_lsr(input umr_pkg::umr_chan_t c,
                                          input logic tx_busy);
      logic [7:0] v;
      v = 8'h00;
      v[`UMR_LSR_RXRDY] = (c.rx_cnt != 8'h00);
      v[`UMR_LSR_RXFULL] = (c.rx_cnt == `UMR_QDEPTH);
      v[`UMR_LSR_TXFULL] = (c.tx_cnt == `UMR_QDEPTH);
      v[`UMR_LSR_TXQEMPTY] = (c.tx_cnt == 8'h00);
      v[`UMR_LSR_TXIDLE] = (c.tx_cnt == 8'h00) && !tx_busy;
      v[`UMR_LSR_RXERR] = (c.err_cnt != 8'h00);
      return v;
   endfunction

   // channel select sits above the low nine offset bits
   assign off = i_req_bus.addr - i_mem_base;
   assign hit = i_req && (off < `UMR_SPAN);
   assign ofs = off[8:0];
   assign sel[0] = hit && !off[9];
   assign sel[1] = hit && off[9];
   assign area = umr_area(ofs);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_chan
         assign rd[g] = sel[g] && !i_req_bus.wr;
         assign wr[g] = sel[g] && i_req_bus.wr;
         assign win_wr[g] = wr[g] && (area != umr_pkg::UMR_AREA_REG);
         // a host window write owns the storage port, so the receiver waits
         assign o_rx_ready[g] = (st_r.ch[g].rx_cnt != `UMR_QDEPTH) && !win_wr[g];
         assign rx_push[g] = i_rx_valid[g] && o_rx_ready[g];
         assign rx_pop[g] = rd[g] && (area == umr_pkg::UMR_AREA_REG) &&
                            (ofs == `UMR_OFS_HOLD) &&
                            (st_r.ch[g].rx_cnt != 8'h00);
         assign tx_push[g] = wr[g] && (area == umr_pkg::UMR_AREA_REG) &&
                             (ofs == `UMR_OFS_HOLD) &&
                             (st_r.ch[g].tx_cnt != `UMR_QDEPTH);
         assign tx_pop[g] = (st_r.ch[g].tx_cnt != 8'h00) && buf_ready[g];
         assign tx_we[g] = tx_push[g];

         umr_txbuf #(
            .WIDTH(8)
         ) u_txbuf (
            .i_mclk(i_mclk),
            .i_nrst(i_nrst),
            .i_valid(st_r.ch[g].tx_cnt != 8'h00),
            .i_data(tx_mem[g][st_r.ch[g].tx_rp]),
            .o_ready(buf_ready[g]),
            .o_valid(o_tx_valid[g]),
            .o_data(o_tx_data[g]),
            .i_ready(i_tx_ready[g])
         );

         assign o_cfg[g].divisor = {st_r.ch[g].divisor_high, st_r.ch[g].dll};
         assign o_cfg[g].line_control = st_r.ch[g].line_control;
         assign o_cfg[g].qctl = st_r.ch[g].qctl;
         assign o_cfg[g].special_function = st_r.ch[g].special_function;
         assign o_cfg[g].sc = st_r.ch[g].scr;
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = hit;
      st_nxt.rdata = 8'h00;
      rx_dwe = '0;
      rx_swe = '0;
      rx_wa = '0;
      rx_wd = '0;
      rx_ws = '0;
      for (int c = 0; c < 2; c++) begin
         // receive side: push from the receiver, or host window write
         if (rx_push[c]) begin
            rx_dwe[c] = 1'b1;
            rx_swe[c] = 1'b1;
            rx_wa[c] = st_r.ch[c].rx_wp;
            rx_wd[c] = i_rx[c].data;
            rx_ws[c] = i_rx[c].stat;
            st_nxt.ch[c].rx_wp = st_r.ch[c].rx_wp + 1'b1;
         end
         if (win_wr[c]) begin
            rx_wa[c] = ofs[`UMR_QAW-1:0];
            rx_wd[c] = i_req_bus.wdata;
            rx_ws[c] = i_req_bus.wdata;
            rx_dwe[c] = (area == umr_pkg::UMR_AREA_DATA);
            rx_swe[c] = (area == umr_pkg::UMR_AREA_STAT);
         end
         if (rx_pop[c]) begin
            st_nxt.ch[c].rx_rp = st_r.ch[c].rx_rp + 1'b1;
         end
         st_nxt.ch[c].rx_cnt = st_r.ch[c].rx_cnt + 8'(rx_push[c]) - 8'(rx_pop[c]);
         // error count tracks queued entries whose status byte is nonzero
         st_nxt.ch[c].err_cnt = st_r.ch[c].err_cnt +
            8'(rx_push[c] && (i_rx[c].stat != 8'h00)) -
            8'(rx_pop[c] && (rx_smem[c][st_r.ch[c].rx_rp] != 8'h00));
         // transmit side: host append at tail, buffer drains the head
         if (tx_push[c]) begin
            st_nxt.ch[c].tx_wp = st_r.ch[c].tx_wp + 1'b1;
         end
         if (tx_pop[c]) begin
            st_nxt.ch[c].tx_rp = st_r.ch[c].tx_rp + 1'b1;
         end
         st_nxt.ch[c].tx_cnt = st_r.ch[c].tx_cnt + 8'(tx_push[c]) - 8'(tx_pop[c]);
         // register writes
         if (wr[c] && (area == umr_pkg::UMR_AREA_REG)) begin
            case (ofs)
               `UMR_OFS_IER: st_nxt.ch[c].interrupt_enable = i_req_bus.wdata;
               `UMR_OFS_QCTL: begin
                  st_nxt.ch[c].qctl = i_req_bus.wdata;
                  if (i_req_bus.wdata[`UMR_QCTL_RXFLUSH]) begin
                     st_nxt.ch[c].rx_wp = '0;
                     st_nxt.ch[c].rx_rp = '0;
                     st_nxt.ch[c].rx_cnt = 8'h00;
                     st_nxt.ch[c].err_cnt = 8'h00;
                  end
                  if (i_req_bus.wdata[`UMR_QCTL_TXFLUSH]) begin
                     st_nxt.ch[c].tx_wp = '0;
                     st_nxt.ch[c].tx_rp = '0;
                     st_nxt.ch[c].tx_cnt = 8'h00;
                  end
               end
               `UMR_OFS_LCTL: st_nxt.ch[c].line_control = i_req_bus.wdata;
               `UMR_OFS_SFR: st_nxt.ch[c].special_function = i_req_bus.wdata;
               `UMR_OFS_DLL: st_nxt.ch[c].dll = i_req_bus.wdata;
               `UMR_OFS_DLH: st_nxt.ch[c].divisor_high = i_req_bus.wdata;
               `UMR_OFS_EFR: st_nxt.ch[c].enhanced_function = i_req_bus.wdata;
               `UMR_OFS_RESUME_CHAR_FIRST: st_nxt.ch[c].resume_char_first = i_req_bus.wdata;
               `UMR_OFS_RESUME_CHAR_SECOND: st_nxt.ch[c].resume_char_second = i_req_bus.wdata;
               `UMR_OFS_PAUSE_CHAR_FIRST: st_nxt.ch[c].pause_char_first = i_req_bus.wdata;
               `UMR_OFS_PAUSE_CHAR_SECOND: st_nxt.ch[c].pause_char_second = i_req_bus.wdata;
               `UMR_OFS_ACR: st_nxt.ch[c].acr = i_req_bus.wdata;
               `UMR_OFS_TTL: st_nxt.ch[c].ttl = i_req_bus.wdata;
               `UMR_OFS_RTL: st_nxt.ch[c].rx_irq_trigger_level = i_req_bus.wdata;
               `UMR_OFS_FCL: st_nxt.ch[c].flow_lower_threshold = i_req_bus.wdata;
               `UMR_OFS_FCH: st_nxt.ch[c].flow_upper_threshold = i_req_bus.wdata;
               `UMR_OFS_CPR: st_nxt.ch[c].baud_prescale = i_req_bus.wdata;
               `UMR_OFS_TXCNT: begin
                  // the count view is read-only, so only the clock view takes it
                  if (!st_r.ch[c].special_function[`UMR_SFR_TXSEL]) begin
                     st_nxt.ch[c].scr = i_req_bus.wdata[3:0];
                  end
               end
               `UMR_OFS_GLOBAL_LINE_STATUS: st_nxt.ch[c].global_line_status = i_req_bus.wdata;
               default: ;
            endcase
         end
         // register and window reads, answered one cycle later
         if (rd[c]) begin
            if (area == umr_pkg::UMR_AREA_DATA) begin
               st_nxt.rdata = rx_dmem[c][ofs[`UMR_QAW-1:0]];
            end else if (area == umr_pkg::UMR_AREA_STAT) begin
               st_nxt.rdata = rx_smem[c][ofs[`UMR_QAW-1:0]];
            end else begin
               case (ofs)
                  // an empty queue still shows the stale head byte
                  `UMR_OFS_HOLD: st_nxt.rdata = rx_dmem[c][st_r.ch[c].rx_rp];
                  `UMR_OFS_IER: st_nxt.rdata = st_r.ch[c].interrupt_enable;
                  `UMR_OFS_QCTL: st_nxt.rdata = umr_isr(st_r.ch[c]);
                  `UMR_OFS_LCTL: st_nxt.rdata = st_r.ch[c].line_control;
                  `UMR_OFS_LSTAT: st_nxt.rdata = umr_lsr(st_r.ch[c], o_tx_valid[c]);
                  `UMR_OFS_SFR: st_nxt.rdata = st_r.ch[c].special_function;
                  `UMR_OFS_EFR: st_nxt.rdata = st_r.ch[c].enhanced_function;
                  `UMR_OFS_RESUME_CHAR_FIRST: st_nxt.rdata = st_r.ch[c].resume_char_first;
                  `UMR_OFS_RESUME_CHAR_SECOND: st_nxt.rdata = st_r.ch[c].resume_char_second;
                  `UMR_OFS_PAUSE_CHAR_FIRST: st_nxt.rdata = st_r.ch[c].pause_char_first;
                  `UMR_OFS_PAUSE_CHAR_SECOND: st_nxt.rdata = st_r.ch[c].pause_char_second;
                  `UMR_OFS_ACR: st_nxt.rdata = st_r.ch[c].acr;
                  `UMR_OFS_TTL: st_nxt.rdata = st_r.ch[c].ttl;
                  `UMR_OFS_RTL: st_nxt.rdata = st_r.ch[c].rx_irq_trigger_level;
                  `UMR_OFS_FCL: st_nxt.rdata = st_r.ch[c].flow_lower_threshold;
                  `UMR_OFS_FCH: st_nxt.rdata = st_r.ch[c].flow_upper_threshold;
                  `UMR_OFS_CPR: st_nxt.rdata = st_r.ch[c].baud_prescale;
                  `UMR_OFS_RXCNT: begin
                     st_nxt.rdata = st_r.ch[c].special_function[`UMR_SFR_ERRSEL] ?
                        st_r.ch[c].err_cnt : st_r.ch[c].rx_cnt;
                  end
                  `UMR_OFS_TXCNT: begin
                     st_nxt.rdata = st_r.ch[c].special_function[`UMR_SFR_TXSEL] ?
                        st_r.ch[c].tx_cnt : {4'h0, st_r.ch[c].scr};
                  end
                  `UMR_OFS_GLOBAL_LINE_STATUS: st_nxt.rdata = st_r.ch[c].global_line_status;
                  default: st_nxt.rdata = 8'h00;
               endcase
            end
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge i_mclk) begin
      for (int c = 0; c < 2; c++) begin
         if (rx_dwe[c]) begin
            rx_dmem[c][rx_wa[c]] <= rx_wd[c];
         end
         if (rx_swe[c]) begin
            rx_smem[c][rx_wa[c]] <= rx_ws[c];
         end
         if (tx_we[c]) begin
            tx_mem[c][st_r.ch[c].tx_wp] <= i_req_bus.wdata;
         end
      end
   end

   assign o_ack = st_r.ack;
   assign o_rdata = st_r.rdata;

   chk_ack_one_cycle: assert property (
      @(posedge i_mclk) disable iff (!i_nrst) hit |=> o_ack ##1 !o_ack || $past(hit))
      else $error("request not answered in one cycle");

   chk_unmapped_zero: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      rd[1] && (ofs == 9'h003) |=> (o_rdata == 8'h00))
      else $error("unmapped offset read nonzero");

   chk_isr_code: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      rd[0] && (ofs == `UMR_OFS_QCTL) |=> (o_rdata[7:6] == 2'b11))
      else $error("interrupt status code malformed");

   chk_divisor_wonly: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      rd[1] && ((ofs == `UMR_OFS_DLL) || (ofs == `UMR_OFS_DLH)) |=> (o_rdata == 8'h00))
      else $error("divisor byte readable");

   chk_chan1_divisor: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      wr[1] && (ofs == `UMR_OFS_DLL) |=> (o_cfg[1].divisor[7:0] == $past(i_req_bus.wdata)))
      else $error("second channel divisor not loaded");

   chk_rx_pop_step: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      rx_pop[0] && !rx_push[0] && !wr[0] |=>
         (st_r.ch[0].rx_cnt == $past(st_r.ch[0].rx_cnt) - 8'h01))
      else $error("receive read did not pop one entry");

   chk_tx_full_drop: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      wr[1] && (ofs == `UMR_OFS_HOLD) && (st_r.ch[1].tx_cnt == `UMR_QDEPTH) |=>
         (st_r.ch[1].tx_wp == $past(st_r.ch[1].tx_wp)))
      else $error("write to full transmit queue accepted");

   chk_tx_append: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      tx_push[0] |=> (st_r.ch[0].tx_wp == $past(st_r.ch[0].tx_wp) + 7'h01))
      else $error("transmit write not appended");

   chk_lsr_ready: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      rd[0] && (ofs == `UMR_OFS_LSTAT) |=>
         (o_rdata[`UMR_LSR_RXRDY] == ($past(st_r.ch[0].rx_cnt) != 8'h00)))
      else $error("line status ready bit wrong");

   chk_count_select: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      rd[0] && (ofs == `UMR_OFS_RXCNT) && !st_r.ch[0].special_function[`UMR_SFR_ERRSEL] |=>
         (o_rdata == $past(st_r.ch[0].rx_cnt)))
      else $error("receive count view wrong");

endmodule

// ===== umr_params.svh
// umr_params.svh: offsets, field positions, interrupt status codes and sizes of the
// per-channel serial register window.
// assumes inclusion by bare name from the package and the register map.
`ifndef UMR_PARAMS_SVH
`define UMR_PARAMS_SVH

// window geometry: two channels of 512 bytes each
`define UMR_CHAN0_OFS 32'h0000_0000
`define UMR_CHAN1_OFS 32'h0000_0200
`define UMR_SPAN 32'h0000_0400
`define UMR_QAW 7
`define UMR_QDEPTH 8'h80

// register offsets inside one channel window
`define UMR_OFS_HOLD 9'h000
`define UMR_OFS_IER 9'h001
`define UMR_OFS_QCTL 9'h002
`define UMR_OFS_LCTL 9'h004
`define UMR_OFS_LSTAT 9'h005
`define UMR_OFS_MSTAT 9'h006
`define UMR_OFS_SFR 9'h007
`define UMR_OFS_DLL 9'h008
`define UMR_OFS_DLH 9'h009
`define UMR_OFS_EFR 9'h00A
`define UMR_OFS_RESUME_CHAR_FIRST 9'h00B
`define UMR_OFS_RESUME_CHAR_SECOND 9'h00C
`define UMR_OFS_PAUSE_CHAR_FIRST 9'h00D
`define UMR_OFS_PAUSE_CHAR_SECOND 9'h00E
`define UMR_OFS_ACR 9'h00F
`define UMR_OFS_TTL 9'h010
`define UMR_OFS_RTL 9'h011
`define UMR_OFS_FCL 9'h012
`define UMR_OFS_FCH 9'h013
`define UMR_OFS_CPR 9'h014
`define UMR_OFS_RXCNT 9'h015
`define UMR_OFS_TXCNT 9'h016
`define UMR_OFS_GLOBAL_LINE_STATUS 9'h017

// field positions
`define UMR_SFR_ERRSEL 6
`define UMR_SFR_TXSEL 7
`define UMR_QCTL_RXFLUSH 1
`define UMR_QCTL_TXFLUSH 2
`define UMR_IER_RXAV 0
`define UMR_IER_TXE 1
`define UMR_IER_RXERR 2
`define UMR_LSR_RXRDY 0
`define UMR_LSR_RXFULL 1
`define UMR_LSR_TXFULL 4
`define UMR_LSR_TXQEMPTY 5
`define UMR_LSR_TXIDLE 6
`define UMR_LSR_RXERR 7

// interrupt status codes
`define UMR_ISR_NONE 8'hC1
`define UMR_ISR_RXERR 8'hC6
`define UMR_ISR_RXAV 8'hC4
`define UMR_ISR_TXE 8'hC2

`endif

// ===== umr_pkg.sv
// umr_pkg.sv: types shared by the register map, the stream model and the bench.
// assumes umr_params.svh is on the include path.
`include "umr_params.svh"

package umr_pkg;

   typedef enum logic [1:0] {
      UMR_AREA_REG = 2'b00,
      UMR_AREA_DATA = 2'b01,
      UMR_AREA_STAT = 2'b10
   } umr_area_t;

   typedef struct packed {
      logic wr;
      logic [31:0] addr;
      logic [7:0] wdata;
   } umr_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] stat;
   } umr_rx_t;

   typedef struct packed {
      logic [15:0] divisor;
      logic [7:0] line_control;
      logic [7:0] qctl;
      logic [7:0] special_function;
      logic [3:0] sc;
   } umr_cfg_t;

   typedef struct packed {
      logic [7:0] interrupt_enable;
      logic [7:0] qctl;
      logic [7:0] line_control;
      logic [7:0] special_function;
      logic [7:0] dll;
      logic [7:0] divisor_high;
      logic [7:0] enhanced_function;
      logic [7:0] resume_char_first;
      logic [7:0] resume_char_second;
      logic [7:0] pause_char_first;
      logic [7:0] pause_char_second;
      logic [7:0] acr;
      logic [7:0] ttl;
      logic [7:0] rx_irq_trigger_level;
      logic [7:0] flow_lower_threshold;
      logic [7:0] flow_upper_threshold;
      logic [7:0] baud_prescale;
      logic [7:0] global_line_status;
      logic [3:0] scr;
      logic [`UMR_QAW-1:0] rx_wp;
      logic [`UMR_QAW-1:0] rx_rp;
      logic [`UMR_QAW-1:0] tx_wp;
      logic [`UMR_QAW-1:0] tx_rp;
      logic [7:0] rx_cnt;
      logic [7:0] tx_cnt;
      logic [7:0] err_cnt;
   } umr_chan_t;

   typedef struct packed {
      umr_chan_t [1:0] ch;
      logic [7:0] rdata;
      logic ack;
   } umr_state_t;

endpackage

// ===== umr_txbuf.sv
// umr_txbuf.sv: two-entry buffer between the transmit queue and the
// serializer, so a serializer stall never drops a byte.
// assumes both sides on i_mclk; data out comes straight from a flop.
`timescale 1ns/1ps

module umr_txbuf #(
   parameter int WIDTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);

   typedef struct packed {
      logic [WIDTH-1:0] d0;
      logic [WIDTH-1:0] d1;
      logic [1:0] cnt;
   } umr_buf_st_t;

   umr_buf_st_t st_r;
   umr_buf_st_t st_nxt;
   logic push;
   logic pop;

   assign o_ready = (st_r.cnt != 2'd2);
   assign o_valid = (st_r.cnt != 2'd0);
   assign o_data = st_r.d0;
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   always_comb begin
      st_nxt = st_r;
      if (pop) begin
         st_nxt.d0 = st_r.d1;
      end
      // the slot to fill shifts down when a pop happens in the same cycle
      if (push) begin
         if ((st_r.cnt - 2'(pop)) == 2'd0) begin
            st_nxt.d0 = i_data;
         end else begin
            st_nxt.d1 = i_data;
         end
      end
      st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// ===== umr_stream_model.sv
// umr_stream_model.sv: receiver source and serializer sink for both channels.
// assumes the bench queues bytes by push_rx and stalls the sink by i_stall.
`timescale 1ns/1ps

module umr_stream_model (
   input wire logic i_mclk,
   input wire logic [1:0] i_rx_ready,
   input wire logic [1:0] i_stall,
   output logic [1:0] o_rx_valid,
   output umr_pkg::umr_rx_t [1:0] o_rx,
   output logic [1:0] o_tx_ready
);
   umr_pkg::umr_rx_t src_q[2][$];

   task automatic push_rx(input int ch, input umr_pkg::umr_rx_t v);
      src_q[ch].push_back(v);
   endtask

   initial begin
      o_rx_valid = 2'h0;
      o_rx = '0;
      o_tx_ready = 2'h0;
   end

   // idle data is inverted each cycle so a stale byte never passes as new
   always @(posedge i_mclk) begin
      o_tx_ready <= ~i_stall;
      for (int c = 0; c < 2; c++) begin
         if (o_rx_valid[c] && i_rx_ready[c]) begin
            void'(src_q[c].pop_front());
         end
         o_rx_valid[c] <= src_q[c].size() > 0;
         o_rx[c] <= (src_q[c].size() > 0) ? src_q[c][0] : ~o_rx[c];
      end
   end
endmodule

// ===== test_uart_memory_register_map.sv
// test_uart_memory_register_map.sv: self-checking bench for the register window.
// assumes umr_pkg and umr_regmap are compiled first; one 100 MHz clock.
`timescale 1ns/1ps

module test_uart_memory_register_map;
   localparam logic RD = 1'b0;
   localparam logic WR = 1'b1;
   localparam logic [8:0] OFS [21] = '{9'h001, 9'h004, 9'h007, 9'h00A, 9'h00B,
      9'h00C, 9'h00D, 9'h00E, 9'h00F, 9'h010, 9'h011, 9'h012, 9'h013, 9'h014,
      9'h017, 9'h003, 9'h006, 9'h008, 9'h015, 9'h018, 9'h0FF};
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic [31:0] mem_base = 32'h0000_0000;
   logic req = 1'b0;
   umr_pkg::umr_req_t req_bus = '0;
   logic ack;
   logic [7:0] rdata;
   logic [1:0] rx_valid;
   logic [1:0] rx_ready;
   logic [1:0] tx_valid;
   logic [1:0] tx_ready;
   logic [1:0] stall = 2'h0;
   logic [1:0] stall_fix = 2'h0;
   logic rand_stall = 1'b0;
   umr_pkg::umr_rx_t [1:0] rx;
   logic [1:0][7:0] tx_data;
   umr_pkg::umr_cfg_t [1:0] cfg;
   int mismatches = 0;
   int check_count = 0;
   int seed = 6096;
   logic [8:0] exp_q[$];
   logic [7:0] tx_exp[2][$];

   always #5 i_mclk = ~i_mclk;

   umr_regmap i_umr_regmap (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_mem_base(mem_base),
      .i_req(req), .i_req_bus(req_bus), .o_ack(ack), .o_rdata(rdata),
      .i_rx_valid(rx_valid), .i_rx(rx), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
      .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_cfg(cfg));

   umr_stream_model i_umr_stream_model (.i_mclk(i_mclk), .i_rx_ready(rx_ready),
      .i_stall(stall), .o_rx_valid(rx_valid), .o_rx(rx), .o_tx_ready(tx_ready));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ofs bit 9 picks the channel; bit 10 set means outside the window, no answer
   task automatic acc(input logic wr, input logic [10:0] ofs, input logic [7:0] wd,
         input logic [7:0] ex, input logic x_ok = 1'b0);
      @(posedge i_mclk);
      if (!ofs[10]) begin
         exp_q.push_back({x_ok, wr ? 8'h00 : ex});
      end
      req <= 1'b1;
      req_bus <= '{wr: wr, addr: mem_base + 32'(ofs), wdata: wd};
      @(posedge i_mclk);
      req <= 1'b0;
   endtask

   task automatic final_report();
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // an answer or a byte with no note compares against unknown and fails
   always @(posedge i_mclk) begin
      logic [8:0] e;
      // stall has this one driver, so the bench never assigns it twice in a step
      stall <= rand_stall ? 2'($random(seed)) : stall_fix;
      if (ack === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 9'b0_xxxx_xxxx;
         if (!e[8]) begin
            check(rdata, e[7:0]);
         end
      end
      for (int c = 0; c < 2; c++) begin
         if (tx_valid[c] === 1'b1 && tx_ready[c] === 1'b1) begin
            check(tx_data[c], tx_exp[c].size() > 0 ? tx_exp[c].pop_front() : 8'hxx);
         end
      end
   end

   initial begin
      #100us;
      mismatches++;
      final_report();
   end

   initial begin
      logic [7:0] d;
      logic [7:0] rxd [3];
      repeat (12) @(posedge i_mclk);
      mem_base <= 32'($random(seed)) & 32'h7FFF_FFFF;
      i_nrst <= 1'b1;
      acc(RD, 11'h005, 8'h00, 8'h60);
      acc(RD, 11'h202, 8'h00, 8'hC1);
      d = 8'($random(seed));
      acc(WR, 11'h208, d, 8'h00);
      acc(WR, 11'h209, ~d, 8'h00);
      acc(RD, 11'h208, 8'h00, 8'h00);
      check(cfg[1].divisor, {~d, d});
      check(cfg[0].divisor, 16'h0000);
      foreach (OFS[i]) begin
         d = 8'($random(seed));
         acc(WR, {1'b0, i[0], OFS[i]}, d, 8'h00);
         acc(RD, {1'b0, i[0], OFS[i]}, 8'h00, i < 15 ? d : 8'h00);
         if (i == 1) begin
            check(cfg[1].line_control, {8'h00, d});
         end
      end
      acc(WR, 11'h400, 8'h55, 8'h00);
      acc(RD, 11'h7FF, 8'h00, 8'h00);
      acc(WR, 11'h007, 8'h00, 8'h00);
      acc(WR, 11'h001, 8'h05, 8'h00);
      for (int k = 0; k < 3; k++) begin
         rxd[k] = 8'($random(seed));
         i_umr_stream_model.push_rx(0, '{data: rxd[k], stat: k == 1 ? 8'h02 : 8'h00});
      end
      repeat (10) @(posedge i_mclk);
      acc(RD, 11'h015, 8'h00, 8'h03);
      acc(WR, 11'h007, 8'h40, 8'h00);
      acc(RD, 11'h015, 8'h00, 8'h01);
      acc(RD, 11'h005, 8'h00, 8'hE1);
      acc(RD, 11'h002, 8'h00, 8'hC6);
      for (int k = 0; k < 3; k++) begin
         acc(RD, 11'h100 + 11'(k), 8'h00, rxd[k]);
         acc(RD, 11'h180 + 11'(k), 8'h00, k == 1 ? 8'h02 : 8'h00);
      end
      acc(WR, 11'h102, 8'h3C, 8'h00);
      rxd[2] = 8'h3C;
      for (int k = 0; k < 3; k++) begin
         acc(RD, 11'h000, 8'h00, rxd[k]);
      end
      acc(RD, 11'h000, 8'h00, 8'h00, 1'b1);
      acc(RD, 11'h015, 8'h00, 8'h00);
      acc(RD, 11'h002, 8'h00, 8'hC1);
      acc(WR, 11'h007, 8'h00, 8'h00);
      i_umr_stream_model.push_rx(0, '{data: 8'h11, stat: 8'h00});
      i_umr_stream_model.push_rx(0, '{data: 8'h22, stat: 8'h00});
      repeat (6) @(posedge i_mclk);
      acc(RD, 11'h015, 8'h00, 8'h02);
      acc(RD, 11'h002, 8'h00, 8'hC4);
      acc(WR, 11'h002, 8'h02, 8'h00);
      acc(RD, 11'h015, 8'h00, 8'h00);
      check(cfg[0].qctl, 16'h0002);
      acc(WR, 11'h016, 8'hA5, 8'h00);
      acc(RD, 11'h016, 8'h00, 8'h05);
      check(cfg[0].sc, 16'h0005);
      // channel 1 serializer stalled: 128 queued plus 2 in the buffer, rest dropped
      stall_fix <= 2'b10;
      acc(WR, 11'h207, 8'h80, 8'h00);
      for (int k = 0; k < 140; k++) begin
         d = 8'($random(seed));
         if (k < 130) begin
            tx_exp[1].push_back(d);
         end
         acc(WR, 11'h200, d, 8'h00);
      end
      acc(RD, 11'h216, 8'h00, 8'h80);
      check(cfg[1].special_function, 16'h0080);
      acc(RD, 11'h205, 8'h00, 8'h10);
      for (int k = 0; k < 4; k++) begin
         d = 8'($random(seed));
         tx_exp[0].push_back(d);
         acc(WR, 11'h000, d, 8'h00);
      end
      rand_stall <= 1'b1;
      for (int n = 0; n < 3000 && tx_exp[1].size() + tx_exp[0].size() > 0; n++) begin
         @(posedge i_mclk);
      end
      rand_stall <= 1'b0;
      stall_fix <= 2'b00;
      repeat (4) @(posedge i_mclk);
      acc(RD, 11'h216, 8'h00, 8'h00);
      acc(RD, 11'h205, 8'h00, 8'h60);
      acc(WR, 11'h001, 8'h02, 8'h00);
      acc(RD, 11'h002, 8'h00, 8'hC2);
      repeat (4) @(posedge i_mclk);
      check(16'(exp_q.size() + tx_exp[0].size() + tx_exp[1].size()), 16'h0000);
      final_report();
   end
endmodule
